// ---- dacrt_regs.svh ----
`ifndef DACRT_REGS_SVH
`define DACRT_REGS_SVH

// ***************************************************************
// Clock and timing figures
// ***************************************************************
`define DACRT_CLK_NS          5
`define DACRT_CONV_NS         1250
`define DACRT_CONV_CYC        (`DACRT_CONV_NS / `DACRT_CLK_NS)
`define DACRT_SYNC_LAT        3
`define DACRT_SCLK_MAX_MHZ    20
`define DACRT_SCLK_MIN_KHZ    10
`define DACRT_SCLK_PER_MIN_NS (1000 / `DACRT_SCLK_MAX_MHZ)
`define DACRT_SCLK_HALF_MIN_CYC \
  ((`DACRT_SCLK_PER_MIN_NS + 2 * `DACRT_CLK_NS - 1) / (2 * `DACRT_CLK_NS))
`define DACRT_SCLK_HALF_CYC   (2 * `DACRT_SCLK_HALF_MIN_CYC)
`define DACRT_QUIET_NS        50
`define DACRT_QUIET_CYC       ((`DACRT_QUIET_NS + `DACRT_CLK_NS - 1) / `DACRT_CLK_NS)
`define DACRT_START_LOW_NS    10
`define DACRT_START_LOW_CYC   ((`DACRT_START_LOW_NS + `DACRT_CLK_NS - 1) / `DACRT_CLK_NS)
`define DACRT_PWRUP_NS        70000
`define DACRT_PWRUP_CYC       (`DACRT_PWRUP_NS / `DACRT_CLK_NS)

// ***************************************************************
// Word layout and synchroniser lanes
// ***************************************************************
`define DACRT_WORD_W          14
`define DACRT_FRAME_BITS      (2 * `DACRT_WORD_W)
`define DACRT_SY_START        0
`define DACRT_SY_CS           1
`define DACRT_SY_SCLK         2
`define DACRT_SY_CHAN         3
`define DACRT_SYNC_RST        4'h7

`endif

// ---- dacrt_pkg.sv ----
`default_nettype none
`include "dacrt_regs.svh"

package dacrt_pkg;
  typedef logic [`DACRT_WORD_W-1:0]     dacrt_word_t;
  typedef logic [`DACRT_FRAME_BITS-1:0] dacrt_frame_t;
  typedef enum logic [0:0] {DACRT_D_IDLE, DACRT_D_CONV} dacrt_dev_state_t;
  typedef enum logic [3:0] {
    DACRT_H_IDLE, DACRT_H_WAKE, DACRT_H_START, DACRT_H_BUSY_HI, DACRT_H_BUSY_LO,
    DACRT_H_SETUP, DACRT_H_HIGH, DACRT_H_LOW, DACRT_H_QUIET
  } dacrt_host_state_t;
endpackage

`default_nettype wire

// ---- dacrt_if.sv ----
`default_nettype none

// ***************************************************************
// Pin bundle between converter and host
// ***************************************************************
interface dacrt_if;
  logic conversion_start_n;
  logic busy;
  logic chan_sel;
  logic cs_n;
  logic sclk;
  logic serial_out_first;
  logic serial_out_first_oe;
  logic serial_out_second;
  logic serial_out_second_oe;

  modport dev (
    input  conversion_start_n, chan_sel, cs_n, sclk,
    output busy, serial_out_first, serial_out_first_oe,
           serial_out_second, serial_out_second_oe
  );

  modport host (
    output conversion_start_n, chan_sel, cs_n, sclk,
    input  busy, serial_out_first, serial_out_first_oe
  );
endinterface

`default_nettype wire

// ---- dacrt_dev.sv ----
// Functional notes
// - Busy falls within 1.25 us of start
// - Busy rises after start falling edge
// - Host read clock between 10 kHz, 20 MHz
// - Host waits 50 ns after read
// - Start low pulse at least 10 ns
// - MSB shown as busy falls
// - Outputs driven only while select is low
// - Next bit after each clock fall
// - Host allows 70 us wake-up time
// - Channel pair latched on busy rise
// - 14-bit MSB first, other result follows
`default_nettype none
`include "dacrt_regs.svh"

module dacrt_dev (
  input  wire logic           clk_in,
  input  wire logic           nrst_in,
  dacrt_if.dev                link,
  input  wire logic [13:0]    a_ch1_in,
  input  wire logic [13:0]    a_ch2_in,
  input  wire logic [13:0]    b_ch1_in,
  input  wire logic [13:0]    b_ch2_in,
  output logic                conv_done_out,
  output logic                mux_sel_out
);

  // ***************************************************************
  // Local constants
  // ***************************************************************
  // Pin synchroniser eats part of the budget, so finish early
  localparam logic [8:0] CONV_END = 9'(`DACRT_CONV_CYC - `DACRT_SYNC_LAT - 1);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [3:0]                sync1_r;
  logic [3:0]                sync2_r;
  logic [3:0]                prev_r;
  dacrt_pkg::dacrt_dev_state_t state_r;
  logic [8:0]                cnt_r;
  logic                      busy_r;
  logic                      mux_sel_r;
  dacrt_pkg::dacrt_word_t    hold_a_r;
  dacrt_pkg::dacrt_word_t    hold_b_r;
  dacrt_pkg::dacrt_word_t    res_a_r;
  dacrt_pkg::dacrt_word_t    res_b_r;
  dacrt_pkg::dacrt_frame_t   shift_a_r;
  dacrt_pkg::dacrt_frame_t   shift_b_r;
  logic                      oe_r;
  logic                      done_r;
  logic                      start_fall;
  logic                      cs_fall;
  logic                      sclk_fall;
  logic                      cs_low;
  logic                      conv_end;
  logic                      start_take;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // High-to-low step between the edge stage and the second sync stage
  function automatic logic fell_edge(input logic was_v, input logic now_v);
    return was_v & ~now_v;
  endfunction

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Two stages before any logic; third stage only for edges
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= `DACRT_SYNC_RST;
      sync2_r <= `DACRT_SYNC_RST;
      prev_r  <= `DACRT_SYNC_RST;
    end else begin
      sync1_r <= {link.chan_sel, link.sclk, link.cs_n, link.conversion_start_n};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edge and level decode of the synchronised pins
  assign start_fall = fell_edge(prev_r[`DACRT_SY_START], sync2_r[`DACRT_SY_START]);
  assign cs_fall    = fell_edge(prev_r[`DACRT_SY_CS], sync2_r[`DACRT_SY_CS]);
  assign sclk_fall  = fell_edge(prev_r[`DACRT_SY_SCLK], sync2_r[`DACRT_SY_SCLK]);
  assign cs_low     = ~sync2_r[`DACRT_SY_CS];
  assign conv_end   = (state_r == dacrt_pkg::DACRT_D_CONV) && (cnt_r == CONV_END);
  // Only a start seen while idle opens a conversion
  assign start_take = start_fall && (state_r == dacrt_pkg::DACRT_D_IDLE);

  // ***************************************************************
  // Conversion sequencer
  // ***************************************************************
  // Starts arriving mid-conversion are ignored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= dacrt_pkg::DACRT_D_IDLE;
      cnt_r   <= 9'h000;
    end else begin
      unique case (state_r)
        dacrt_pkg::DACRT_D_IDLE: begin
          cnt_r <= 9'h000;
          if (start_fall) begin
            state_r <= dacrt_pkg::DACRT_D_CONV;
          end
        end
        dacrt_pkg::DACRT_D_CONV: begin
          if (conv_end) begin
            state_r <= dacrt_pkg::DACRT_D_IDLE;
          end else begin
            cnt_r <= cnt_r + 9'h001;
          end
        end
      endcase
    end
  end

  // Busy flag follows the sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_r <= 1'b0;
    end else if (start_take) begin
      busy_r <= 1'b1;
    end else if (conv_end) begin
      busy_r <= 1'b0;
    end
  end

  // ***************************************************************
  // Track and hold, channel pair select
  // ***************************************************************
  // Hold uses the pair latched last time; new pair is latched as busy rises
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mux_sel_r <= 1'b0;
      hold_a_r  <= '0;
      hold_b_r  <= '0;
    end else if (start_take) begin
      hold_a_r  <= mux_sel_r ? a_ch2_in : a_ch1_in;
      hold_b_r  <= mux_sel_r ? b_ch2_in : b_ch1_in;
      mux_sel_r <= sync2_r[`DACRT_SY_CHAN];
    end
  end

  // Results become visible only at the end of conversion
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_a_r <= '0;
      res_b_r <= '0;
    end else if (conv_end) begin
      res_a_r <= hold_a_r;
      res_b_r <= hold_b_r;
    end
  end

  // ***************************************************************
  // Serial shifters
  // ***************************************************************
  // Each lane carries its own result then the other one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_a_r <= '0;
      shift_b_r <= '0;
    end else if (conv_end) begin
      shift_a_r <= {hold_a_r, hold_b_r};
      shift_b_r <= {hold_b_r, hold_a_r};
    end else if (cs_fall && !busy_r) begin
      shift_a_r <= {res_a_r, res_b_r};
      shift_b_r <= {res_b_r, res_a_r};
    end else if (sclk_fall && cs_low && !busy_r) begin
      shift_a_r <= {shift_a_r[`DACRT_FRAME_BITS-2:0], 1'b0};
      shift_b_r <= {shift_b_r[`DACRT_FRAME_BITS-2:0], 1'b0};
    end
  end

  // Output enable tracks the synchronised select
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= cs_low;
    end
  end

  // One-cycle strobe for the user side when a result lands
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_r <= 1'b0;
    end else begin
      done_r <= conv_end;
    end
  end

  // ***************************************************************
  // Pin and user outputs
  // ***************************************************************
  // Past the frame the lanes shift out zeros
  assign link.busy                 = busy_r;
  assign link.serial_out_first     = shift_a_r[`DACRT_FRAME_BITS-1];
  assign link.serial_out_second    = shift_b_r[`DACRT_FRAME_BITS-1];
  assign link.serial_out_first_oe  = oe_r;
  assign link.serial_out_second_oe = oe_r;
  assign conv_done_out             = done_r;
  assign mux_sel_out               = mux_sel_r;

endmodule

`default_nettype wire

// ---- dacrt_host.sv ----
`default_nettype none
`include "dacrt_regs.svh"

module dacrt_host #(
  parameter int PWRUP_CYC = `DACRT_PWRUP_CYC
) (
  input  wire logic           clk_in,
  input  wire logic           nrst_in,
  dacrt_if.host               link,
  input  wire logic           start_in,
  input  wire logic           chan_in,
  input  wire logic           wake_in,
  input  wire logic           res_ready_in,
  output logic                res_valid_out,
  output logic [13:0]         res_first_out,
  output logic [13:0]         res_second_out,
  output logic                res_chan_out,
  output logic                idle_out
);

  // ***************************************************************
  // Local constants
  // ***************************************************************
  localparam logic [15:0] HALF_END  = 16'(`DACRT_SCLK_HALF_CYC - 1);
  localparam logic [15:0] LOW_END   = 16'(`DACRT_START_LOW_CYC - 1);
  localparam logic [15:0] QUIET_END = 16'(`DACRT_QUIET_CYC - 1);
  localparam logic [15:0] WAKE_END  = 16'(PWRUP_CYC - 1);
  localparam logic [4:0]  LAST_BIT  = 5'(`DACRT_FRAME_BITS - 1);
  localparam int          ENT_W     = `DACRT_FRAME_BITS + 1;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  dacrt_pkg::dacrt_host_state_t state_r;
  logic [15:0]               cnt_r;
  logic [4:0]                bit_r;
  logic                      start_n_r;
  logic                      cs_n_r;
  logic                      sclk_r;
  logic                      chan_r;
  logic                      mirror_r;
  logic                      tag_r;
  logic [2:0]                sync1_r;
  logic [2:0]                sync2_r;
  dacrt_pkg::dacrt_frame_t   shift_r;
  logic                      push_r;
  logic                      head_v_r;
  logic                      tail_v_r;
  logic [ENT_W-1:0]          head_r;
  logic [ENT_W-1:0]          tail_r;
  logic [ENT_W-1:0]          entry;
  logic                      pop;
  logic                      busy_s;
  logic                      data_s;
  logic                      idle_r;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {link.serial_out_first_oe, link.serial_out_first, link.busy};
      sync2_r <= sync1_r;
    end
  end

  // A floating lane reads as zero
  assign busy_s = sync2_r[0];
  assign data_s = sync2_r[1] & sync2_r[2];

  // ***************************************************************
  // Conversion and read sequencer
  // ***************************************************************
  // A new start waits for a free buffer slot, so no word is dropped
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r   <= dacrt_pkg::DACRT_H_IDLE;
      cnt_r     <= 16'h0000;
      bit_r     <= 5'h00;
      start_n_r <= 1'b1;
      cs_n_r    <= 1'b1;
      sclk_r    <= 1'b1;
      chan_r    <= 1'b0;
      mirror_r  <= 1'b0;
      tag_r     <= 1'b0;
      shift_r   <= '0;
      push_r    <= 1'b0;
    end else begin
      push_r <= 1'b0;
      cnt_r  <= cnt_r + 16'h0001;
      unique case (state_r)
        dacrt_pkg::DACRT_H_IDLE: begin
          cnt_r <= 16'h0000;
          if (start_in && !tail_v_r) begin
            chan_r   <= chan_in;
            tag_r    <= mirror_r;
            mirror_r <= chan_in;
            state_r  <= wake_in ? dacrt_pkg::DACRT_H_WAKE : dacrt_pkg::DACRT_H_START;
            start_n_r <= wake_in;
          end
        end
        dacrt_pkg::DACRT_H_WAKE: begin
          if (cnt_r == WAKE_END) begin
            cnt_r     <= 16'h0000;
            start_n_r <= 1'b0;
            state_r   <= dacrt_pkg::DACRT_H_START;
          end
        end
        dacrt_pkg::DACRT_H_START: begin
          if (cnt_r == LOW_END) begin
            start_n_r <= 1'b1;
            state_r   <= dacrt_pkg::DACRT_H_BUSY_HI;
          end
        end
        dacrt_pkg::DACRT_H_BUSY_HI: begin
          if (busy_s) begin
            state_r <= dacrt_pkg::DACRT_H_BUSY_LO;
          end
        end
        dacrt_pkg::DACRT_H_BUSY_LO: begin
          cnt_r <= 16'h0000;
          bit_r <= 5'h00;
          if (!busy_s) begin
            cs_n_r  <= 1'b0;
            state_r <= dacrt_pkg::DACRT_H_SETUP;
          end
        end
        dacrt_pkg::DACRT_H_SETUP: begin
          if (cnt_r == HALF_END) begin
            cnt_r   <= 16'h0000;
            state_r <= dacrt_pkg::DACRT_H_HIGH;
          end
        end
        dacrt_pkg::DACRT_H_HIGH: begin
          if (cnt_r == HALF_END) begin
            cnt_r   <= 16'h0000;
            shift_r <= {shift_r[`DACRT_FRAME_BITS-2:0], data_s};
            bit_r   <= bit_r + 5'h01;
            if (bit_r == LAST_BIT) begin
              cs_n_r  <= 1'b1;
              push_r  <= 1'b1;
              state_r <= dacrt_pkg::DACRT_H_QUIET;
            end else begin
              sclk_r  <= 1'b0;
              state_r <= dacrt_pkg::DACRT_H_LOW;
            end
          end
        end
        dacrt_pkg::DACRT_H_LOW: begin
          if (cnt_r == HALF_END) begin
            cnt_r   <= 16'h0000;
            sclk_r  <= 1'b1;
            state_r <= dacrt_pkg::DACRT_H_HIGH;
          end
        end
        dacrt_pkg::DACRT_H_QUIET: begin
          if (cnt_r == QUIET_END) begin
            state_r <= dacrt_pkg::DACRT_H_IDLE;
          end
        end
        default: begin
          state_r <= dacrt_pkg::DACRT_H_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Two-entry result buffer
  // ***************************************************************
  // Head is the output stage, tail absorbs one stalled word
  assign entry = {tag_r, shift_r};
  assign pop   = head_v_r & res_ready_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r   <= '0;
      tail_r   <= '0;
    end else if (pop) begin
      if (tail_v_r) begin
        head_r   <= tail_r;
        tail_v_r <= push_r;
        tail_r   <= push_r ? entry : tail_r;
      end else begin
        head_v_r <= push_r;
        head_r   <= entry;
      end
    end else if (push_r) begin
      if (!head_v_r) begin
        head_r   <= entry;
        head_v_r <= 1'b1;
      end else begin
        tail_r   <= entry;
        tail_v_r <= 1'b1;
      end
    end
  end

  // Registered idle flag, equal to the IDLE decode of the next state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_r <= 1'b1;
    end else if (state_r == dacrt_pkg::DACRT_H_IDLE) begin
      idle_r <= !(start_in && !tail_v_r);
    end else begin
      idle_r <= (state_r == dacrt_pkg::DACRT_H_QUIET) && (cnt_r == QUIET_END);
    end
  end

  // ***************************************************************
  // Pin and user outputs
  // ***************************************************************
  assign link.conversion_start_n = start_n_r;
  assign link.cs_n               = cs_n_r;
  assign link.sclk               = sclk_r;
  assign link.chan_sel           = chan_r;
  assign res_valid_out           = head_v_r;
  assign res_first_out           = head_r[`DACRT_FRAME_BITS-1:`DACRT_WORD_W];
  assign res_second_out          = head_r[`DACRT_WORD_W-1:0];
  assign res_chan_out            = head_r[`DACRT_FRAME_BITS];
  assign idle_out                = idle_r;

endmodule

`default_nettype wire

// ---- dacrt_checker.sv ----
`default_nettype none

// ***************************************************************
// Link timing watch, both ends are design code
// ***************************************************************
module dacrt_checker (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic conversion_start_n,
  input  wire logic busy,
  input  wire logic chan_sel,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic serial_out_first,
  input  wire logic serial_out_first_oe,
  input  wire logic serial_out_second,
  input  wire logic serial_out_second_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] gap_r;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Cycles since select went high; saturates so a long idle never wraps
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_r <= 8'hff;
    end else if ($rose(cs_n)) begin
      gap_r <= 8'h00;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  a_busy_rise: assert property ($fell(conversion_start_n) |-> ##[2:4] $rose(busy))
    else $error("busy did not rise after start fell");
  a_conv_limit: assert property ($fell(conversion_start_n) |-> ##[4:250] $fell(busy))
    else $error("conversion ran longer than allowed");
  a_start_width: assert property ($fell(conversion_start_n) |=> !conversion_start_n)
    else $error("start pulse too short");
  a_quiet_gap: assert property ($fell(conversion_start_n) |-> gap_r >= 8'h09)
    else $error("start came too soon after read");
  a_sclk_rate: assert property (($rose(sclk) || $fell(sclk)) |=> $stable(sclk) [*4])
    else $error("read clock phase too short");
  a_read_after_conv: assert property (busy |-> sclk)
    else $error("read clock moved during conversion");
  a_oe_on: assert property ((!cs_n) [*6] |-> serial_out_first_oe && serial_out_second_oe)
    else $error("lanes not driven while selected");
  a_oe_off: assert property (cs_n [*6] |-> !serial_out_first_oe && !serial_out_second_oe)
    else $error("lanes driven while deselected");
  a_chan_hold: assert property ($rose(busy) |-> $stable(chan_sel))
    else $error("pair select moved at busy rise");

  // Main traffic seen at all
  c_conv_end: cover property ($fell(busy));
  c_bit_shift: cover property ($fell(sclk) && !cs_n && serial_out_first);
  c_read_end: cover property ($rose(cs_n) && serial_out_second);
endmodule

`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        chan;
    logic [13:0] first;
    logic [13:0] second;
  } dacrt_exp_t;

  logic        clk_in;
  logic        nrst_in;
  logic        start_r, chan_r, wake_r, ready_r, ready_mode_r;
  logic        prev_chan_r, last_chan_r, sclk_q_r, cs_q_r;
  logic [13:0] a1_r, a2_r, b1_r, b2_r;
  logic [27:0] lane_sh_r;
  logic        res_valid, res_chan, idle, conv_done, mux_sel;
  logic [13:0] res_first, res_second;
  dacrt_exp_t  exp_q[$];
  logic [27:0] lane_q[$];
  int          fail_count;
  int          comparisons;
  integer      seed;

  dacrt_if i_dacrt_if ();

  dacrt_dev i_dacrt_dev (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .link          (i_dacrt_if),
    .a_ch1_in      (a1_r),
    .a_ch2_in      (a2_r),
    .b_ch1_in      (b1_r),
    .b_ch2_in      (b2_r),
    .conv_done_out (conv_done),
    .mux_sel_out   (mux_sel)
  );

  // Short power-up wait keeps the run brief
  dacrt_host #(.PWRUP_CYC(20)) i_dacrt_host (
    .clk_in         (clk_in),
    .nrst_in        (nrst_in),
    .link           (i_dacrt_if),
    .start_in       (start_r),
    .chan_in        (chan_r),
    .wake_in        (wake_r),
    .res_ready_in   (ready_r),
    .res_valid_out  (res_valid),
    .res_first_out  (res_first),
    .res_second_out (res_second),
    .res_chan_out   (res_chan),
    .idle_out       (idle)
  );

  dacrt_checker i_dacrt_checker (
    .clk_in               (clk_in),
    .nrst_in              (nrst_in),
    .conversion_start_n   (i_dacrt_if.conversion_start_n),
    .busy                 (i_dacrt_if.busy),
    .chan_sel             (i_dacrt_if.chan_sel),
    .cs_n                 (i_dacrt_if.cs_n),
    .sclk                 (i_dacrt_if.sclk),
    .serial_out_first     (i_dacrt_if.serial_out_first),
    .serial_out_first_oe  (i_dacrt_if.serial_out_first_oe),
    .serial_out_second    (i_dacrt_if.serial_out_second),
    .serial_out_second_oe (i_dacrt_if.serial_out_second_oe)
  );

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input logic [28:0] seen, input logic [28:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Pre-edge reads only, so state updates at this edge never race us
  task automatic wait_idle();
    int n;
    n = 0;
    while (idle !== 1'b1 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      complete_run();
    end
  endtask

  // Pair picked now converts on the next request, so tag with the old one
  task automatic request(input logic wake);
    logic [13:0] v[4];
    logic        ch;
    dacrt_exp_t  e;
    int          n;
    // A busy host would drop the strobe, so let the last read finish
    wait_idle();
    @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      v[i] = 14'($random(seed));
    end
    ch = 1'($random(seed));
    e.chan = prev_chan_r;
    e.first = prev_chan_r ? v[1] : v[0];
    e.second = prev_chan_r ? v[3] : v[2];
    exp_q.push_back(e);
    lane_q.push_back({e.second, e.first});
    prev_chan_r = ch;
    last_chan_r = ch;
    a1_r <= v[0];
    a2_r <= v[1];
    b1_r <= v[2];
    b2_r <= v[3];
    chan_r <= ch;
    wake_r <= wake;
    start_r <= 1'b1;
    n = 0;
    while (idle !== 1'b0 && n < 40000) begin
      @(posedge clk_in);
      n++;
    end
    start_r <= 1'b0;
    if (n >= 40000) begin
      fail_count++;
      complete_run();
    end
    check(29'(i_dacrt_if.conversion_start_n), 29'(wake), "wake hold");
  endtask

  // ***************************************************************
  // Clock, consumer, monitor
  // ***************************************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Consumer stalls at random to exercise the result buffer
  always @(posedge clk_in) begin
    ready_r <= ready_mode_r ? 1'($random(seed)) : 1'b0;
  end

  // Results and the second lane's wire bits against the noted values
  always @(posedge clk_in) begin
    if (nrst_in === 1'b1) begin
      if (res_valid === 1'b1 && ready_r === 1'b1) begin
        if (exp_q.size() == 0) begin
          check(29'h1, 29'h0, "unexpected result");
        end else begin
          check({res_chan, res_first, res_second}, exp_q.pop_front(), "result");
        end
      end
      if (conv_done === 1'b1) begin
        check(29'(mux_sel), 29'(last_chan_r), "pair latch");
      end
      if (i_dacrt_if.cs_n === 1'b0 && sclk_q_r === 1'b1 && i_dacrt_if.sclk === 1'b0) begin
        lane_sh_r = {lane_sh_r[26:0], i_dacrt_if.serial_out_second};
      end
      if (i_dacrt_if.cs_n === 1'b1 && cs_q_r === 1'b0 && lane_q.size() > 0) begin
        check({1'b0, lane_sh_r[26:0], i_dacrt_if.serial_out_second},
              {1'b0, lane_q.pop_front()}, "second lane frame");
      end
    end
    sclk_q_r = i_dacrt_if.sclk;
    cs_q_r = i_dacrt_if.cs_n;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    seed = 32'h0e5c;
    nrst_in = 1'b0;
    {start_r, chan_r, wake_r, ready_r, ready_mode_r} = 5'h00;
    {prev_chan_r, last_chan_r, sclk_q_r, cs_q_r} = 4'h3;
    {a1_r, a2_r, b1_r, b2_r} = 56'h0;
    lane_sh_r = 28'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    // Fill both buffer entries with the consumer stalled, waking first
    request(1'b1);
    request(1'b0);
    wait_idle();
    fork
      request(1'b0);
      begin
        repeat (400) @(posedge clk_in);
        check(29'(i_dacrt_if.conversion_start_n), 29'h1, "start while full");
        check(29'(res_valid), 29'h1, "held result");
        ready_mode_r <= 1'b1;
      end
    join
    // Back-to-back traffic with random pairs and wake-ups
    for (int i = 0; i < 12; i++) begin
      request(i % 5 == 0);
    end
    wait_idle();
    for (int n = 0; n < 3000 && exp_q.size() > 0; n++) begin
      @(posedge clk_in);
    end
    check(29'(exp_q.size()), 29'h0, "results left");
    check(29'(lane_q.size()), 29'h0, "frames left");
    complete_run();
  end
endmodule

`default_nettype wire
